// ### inc/operand_decode_pkg.sv
`default_nettype none
package operand_decode_pkg;
    // word widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int F_W = 7;
    localparam int PTR_W = 16;
    localparam int BANK_W_DEF = 5;
    localparam int WB_AW = 8;
    // register byte offsets
    localparam logic [WB_AW-1:0] REG_INSTR = 8'h00;
    localparam logic [WB_AW-1:0] REG_BANK = 8'h04;
    localparam logic [WB_AW-1:0] REG_ACC = 8'h08;
    localparam logic [WB_AW-1:0] REG_PTR0 = 8'h0c;
    localparam logic [WB_AW-1:0] REG_PTR1 = 8'h10;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h14;
    // reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
    // instruction field positions and the pointer program memory bit
    localparam int CLS_LSB = 12;
    localparam int OP_LSB = 8;
    localparam int D_BIT = 7;
    localparam int BOP_LSB = 10;
    localparam int B_LSB = 7;
    localparam int X_LSB = 4;
    localparam int X_MSB = 11;
    localparam int DIR_BIT = 3;
    localparam int N_BIT = 2;
    localparam int MM_LSB = 0;
    localparam int PM_BIT = 15;
    // indirect access port addresses
    localparam logic [F_W-1:0] IND_PORT0 = 7'h00;
    localparam logic [F_W-1:0] IND_PORT1 = 7'h01;
    // timing counts
    localparam int PHASES_PER_CYCLE = 4;
    localparam logic [1:0] STRETCH_LAST = 2'h3;

    typedef enum logic [1:0] {
        CLS_BYTE = 2'h0,
        CLS_BIT = 2'h1,
        CLS_IND = 2'h2,
        CLS_NONE = 2'h3
    } class_type;

    typedef enum logic [1:0] {
        MM_PRE_INC = 2'h0,
        MM_PRE_DEC = 2'h1,
        MM_POST_INC = 2'h2,
        MM_POST_DEC = 2'h3
    } step_type;

    typedef enum logic [3:0] {
        BOP_STORE = 4'h0,
        BOP_CLR = 4'h1,
        BOP_MOV = 4'h2,
        BOP_INC = 4'h3,
        BOP_DEC = 4'h4,
        BOP_COM = 4'h5,
        BOP_ADD = 4'h6,
        BOP_AND = 4'h7,
        BOP_OR = 4'h8,
        BOP_XOR = 4'h9
    } byte_op_type;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_READ = 6'h02,
        S_MODIFY = 6'h04,
        S_WRITE = 6'h08,
        S_FINISH = 6'h10,
        S_STRETCH = 6'h20
    } state_type;

    typedef struct packed {
        class_type cls;
        logic [3:0] op;
        logic d;
        logic [F_W-1:0] f;
        logic [2:0] b;
        logic n;
        step_type mm;
        logic dir;
    } fields_type;

    function automatic fields_type decode_fields(input logic [INSTR_W-1:0] w);
        fields_type r;
        r = '0;
        r.cls = class_type'(w[CLS_LSB+:2]);
        r.f = w[F_W-1:0];
        case (r.cls)
            CLS_BYTE: begin
                r.op = w[OP_LSB+:4];
                r.d = w[D_BIT];
            end
            CLS_BIT: begin
                r.op = {2'h0, w[BOP_LSB+:2]};
                r.b = w[B_LSB+:3];
            end
            CLS_IND: begin
                r.f = '0;
                r.dir = w[DIR_BIT];
                r.n = w[N_BIT];
                r.mm = step_type'(w[MM_LSB+:2]);
            end
            default: r.f = '0;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// ### hw/operand_field_extract.sv
`timescale 1ns/1ps
`default_nettype none
module operand_field_extract
    import operand_decode_pkg::*;
(
    // instruction word in
    input wire logic [INSTR_W-1:0] word_i,
    // decoded fields out
    output fields_type fields_o
);
    always_comb begin
        fields_o = decode_fields(word_i);
    end

    // indirect moves carry free bits that must not change the result
    always_comb begin
        chk_dont_care_bits: assert (!(word_i[CLS_LSB+:2] == CLS_IND)
            || decode_fields(word_i) == decode_fields(word_i & ~14'h0ff0))
        else $error("don't-care bits changed the decoded fields");
    end
endmodule
`default_nettype wire

// ### hw/file_register_operand_decode.sv
`timescale 1ns/1ps
`default_nettype none
module file_register_operand_decode
    import operand_decode_pkg::*;
#(
    parameter int BANK_W = BANK_W_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [WB_AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // banked data memory
    output logic [BANK_W+F_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [DATA_W-1:0] mem_wdata_o,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    // status
    output logic busy_o
);
    if (BANK_W < 1 || BANK_W > 8) begin : g_bad_bank
        $error("BANK_W must lie between 1 and 8");
    end

    state_type state_q, state_d;
    fields_type fld_q, fld_d, fld_new;
    logic [INSTR_W-1:0] instr_q, instr_d;
    logic [BANK_W-1:0] bank_q, bank_d;
    logic [DATA_W-1:0] acc_q, acc_d, res_q, res_d;
    logic [PTR_W-1:0] ptr_q [2];
    logic [PTR_W-1:0] ptr_d [2];
    logic [BANK_W+F_W-1:0] addr_q, addr_d;
    logic wr_mem_q, wr_mem_d, wr_acc_q, wr_acc_d, pm_q, pm_d;
    logic [1:0] cnt_q, cnt_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic wr_stb, busy;
    logic [PTR_W-1:0] ptr_sel, ptr_step;

    operand_field_extract u_extract (
        .word_i(dat_i[INSTR_W-1:0]),
        .fields_o(fld_new)
    );

    assign busy = state_q != S_IDLE;
    assign busy_o = busy;
    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign wr_stb = cyc_i && stb_i && we_i && ack_q;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = res_q;
    assign mem_rd_o = state_q == S_READ;
    assign mem_wr_o = state_q == S_WRITE && wr_mem_q;

    // bus slave: one wait state, read data registered with the ack
    always_comb begin
        ack_d = cyc_i && stb_i && !ack_q;
        dat_d = '0;
        if (adr_i == REG_INSTR) begin
            dat_d[INSTR_W-1:0] = instr_q;
        end else if (adr_i == REG_BANK) begin
            dat_d[BANK_W-1:0] = bank_q;
        end else if (adr_i == REG_ACC) begin
            dat_d[DATA_W-1:0] = acc_q;
        end else if (adr_i == REG_PTR0) begin
            dat_d[PTR_W-1:0] = ptr_q[0];
        end else if (adr_i == REG_PTR1) begin
            dat_d[PTR_W-1:0] = ptr_q[1];
        end else if (adr_i == REG_STATUS) begin
            dat_d[$bits(fields_type):0] = {fld_q, busy};
        end
        if (!ack_d) begin
            dat_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // sequencer and core registers
    always_comb begin
        state_d = state_q;
        fld_d = fld_q;
        instr_d = instr_q;
        bank_d = bank_q;
        acc_d = acc_q;
        ptr_d = ptr_q;
        addr_d = addr_q;
        res_d = res_q;
        wr_mem_d = wr_mem_q;
        wr_acc_d = wr_acc_q;
        pm_d = pm_q;
        cnt_d = cnt_q;
        ptr_sel = ptr_q[fld_new.n];
        ptr_step = fld_new.mm inside {MM_PRE_INC, MM_POST_INC} ? ptr_sel + 16'h0001
                                                                : ptr_sel - 16'h0001;
        if (wr_stb && !busy) begin
            if (adr_i == REG_BANK) begin
                bank_d = dat_i[BANK_W-1:0];
            end else if (adr_i == REG_ACC) begin
                acc_d = dat_i[DATA_W-1:0];
            end else if (adr_i == REG_PTR0) begin
                ptr_d[0] = dat_i[PTR_W-1:0];
            end else if (adr_i == REG_PTR1) begin
                ptr_d[1] = dat_i[PTR_W-1:0];
            end
        end
        case (state_q)
            S_IDLE: begin
                if (wr_stb && adr_i == REG_INSTR) begin
                    instr_d = dat_i[INSTR_W-1:0];
                    fld_d = fld_new;
                    state_d = S_READ;
                    addr_d = {bank_q, fld_new.f};
                    pm_d = 1'b0;
                    wr_acc_d = 1'b0;
                    wr_mem_d = 1'b0;
                    case (fld_new.cls)
                        CLS_BYTE: begin
                            wr_acc_d = !fld_new.d;
                            wr_mem_d = fld_new.d;
                            if (fld_new.f == IND_PORT0 || fld_new.f == IND_PORT1) begin
                                ptr_sel = ptr_q[fld_new.f[0]];
                                addr_d = ptr_sel[BANK_W+F_W-1:0];
                                pm_d = ptr_sel[PM_BIT];
                            end
                        end
                        CLS_BIT: wr_mem_d = 1'b1;
                        CLS_IND: begin
                            ptr_d[fld_new.n] = ptr_step;
                            addr_d = fld_new.mm inside {MM_PRE_INC, MM_PRE_DEC}
                                ? ptr_step[BANK_W+F_W-1:0] : ptr_sel[BANK_W+F_W-1:0];
                            pm_d = ptr_sel[PM_BIT];
                            wr_acc_d = !fld_new.dir;
                            wr_mem_d = fld_new.dir;
                        end
                        default: ;
                    endcase
                end
            end
            S_READ: state_d = S_MODIFY;
            S_MODIFY: begin
                state_d = S_WRITE;
                res_d = mem_rdata_i;
                if (fld_q.cls == CLS_BYTE) begin
                    case (byte_op_type'(fld_q.op))
                        BOP_STORE: res_d = acc_q;
                        BOP_CLR: res_d = '0;
                        BOP_INC: res_d = mem_rdata_i + 8'h01;
                        BOP_DEC: res_d = mem_rdata_i - 8'h01;
                        BOP_COM: res_d = ~mem_rdata_i;
                        BOP_ADD: res_d = mem_rdata_i + acc_q;
                        BOP_AND: res_d = mem_rdata_i & acc_q;
                        BOP_OR: res_d = mem_rdata_i | acc_q;
                        BOP_XOR: res_d = mem_rdata_i ^ acc_q;
                        default: ;
                    endcase
                end else if (fld_q.cls == CLS_BIT) begin
                    res_d[fld_q.b] = fld_q.op[0];
                end else if (fld_q.cls == CLS_IND && fld_q.dir) begin
                    res_d = acc_q;
                end
                if (pm_q) begin
                    wr_mem_d = 1'b0;
                end
            end
            S_WRITE: begin
                state_d = S_FINISH;
                if (wr_acc_q) begin
                    acc_d = res_q;
                end
            end
            S_FINISH: begin
                cnt_d = '0;
                state_d = pm_q ? S_STRETCH : S_IDLE;
            end
            S_STRETCH: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == STRETCH_LAST) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            fld_q <= '0;
            instr_q <= '0;
            bank_q <= '0;
            acc_q <= ACC_RST;
            ptr_q[0] <= PTR_RST;
            ptr_q[1] <= PTR_RST;
            addr_q <= '0;
            res_q <= '0;
            wr_mem_q <= 1'b0;
            wr_acc_q <= 1'b0;
            pm_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            fld_q <= fld_d;
            instr_q <= instr_d;
            bank_q <= bank_d;
            acc_q <= acc_d;
            ptr_q <= ptr_d;
            addr_q <= addr_d;
            res_q <= res_d;
            wr_mem_q <= wr_mem_d;
            wr_acc_q <= wr_acc_d;
            pm_q <= pm_d;
            cnt_q <= cnt_d;
        end
    end

    chk_read_before_write: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_wr_o |-> $past(mem_rd_o, 2))
    else $error("file register written without a read two clocks earlier");

    chk_rmw_phases: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_rd_o |=> state_q == S_MODIFY ##1 state_q == S_WRITE ##1 state_q == S_FINISH)
    else $error("read, modify, write phases out of order");

    chk_same_address: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_rd_o |-> ##2 mem_addr_o == $past(mem_addr_o, 2))
    else $error("write phase address differs from read address");

    chk_acc_dest: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_WRITE && fld_q.cls == CLS_BYTE && !fld_q.d |-> !mem_wr_o ##1 acc_q == $past(res_q))
    else $error("accumulator destination not honoured");

    chk_file_dest: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_WRITE && fld_q.cls == CLS_BYTE && fld_q.d && !pm_q |-> mem_wr_o ##1 acc_q == $past(acc_q))
    else $error("file register destination not honoured");

    chk_direct_bank: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_rd_o && (fld_q.cls == CLS_BIT || (fld_q.cls == CLS_BYTE && instr_q[F_W-1:0] > IND_PORT1))
        |-> mem_addr_o == {bank_q, instr_q[F_W-1:0]})
    else $error("direct address does not join bank and file field");

    chk_bit_only: assert property (@(posedge clk_i) disable iff (rst_i)
        state_q == S_WRITE && fld_q.cls == CLS_BIT |->
        (res_q ^ $past(mem_rdata_i)) == ($past(mem_rdata_i[fld_q.b]) == fld_q.op[0] ? 8'h00 : 8'h01 << fld_q.b))
    else $error("bit instruction touched more than the selected bit");

    chk_cycle_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy) && !pm_d |-> busy [*4] ##1 !busy)
    else $error("instruction cycle is not four clocks");

    chk_stretch_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy) && pm_q |-> busy [*8] ##1 !busy)
    else $error("program memory access not stretched by one cycle");
endmodule
`default_nettype wire

// ### sim/data_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module data_memory_model
    import operand_decode_pkg::*;
#(
    parameter int AW = BANK_W_DEF + F_W
) (
    // clock
    input wire logic clk_i,
    // memory port
    input wire logic [AW-1:0] mem_addr_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [DATA_W-1:0] mem_wdata_i,
    output logic [DATA_W-1:0] mem_rdata_o
);
    logic [DATA_W-1:0] mem [0:(1<<AW)-1];
    logic held;
    int rd_cnt;
    int wr_cnt;
    logic [AW-1:0] last_rd;
    logic [AW-1:0] last_wr;

    initial begin
        mem_rdata_o = 8'h00;
        held = 1'b0;
        rd_cnt = 0;
        wr_cnt = 0;
        last_rd = '0;
        last_wr = '0;
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = 8'h00;
        end
    end

    always @(posedge clk_i) begin
        if (mem_rd_i === 1'b1) begin
            mem_rdata_o <= mem[mem_addr_i];
            held <= 1'b1;
            rd_cnt <= rd_cnt + 1;
            last_rd <= mem_addr_i;
        end else if (held) begin
            // read data stands for its one sampling cycle only
            mem_rdata_o <= ~mem_rdata_o;
            held <= 1'b0;
        end
        if (mem_wr_i === 1'b1) begin
            mem[mem_addr_i] <= mem_wdata_i;
            wr_cnt <= wr_cnt + 1;
            last_wr <= mem_addr_i;
        end
    end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import operand_decode_pkg::*;
();
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [WB_AW-1:0] adr_i = '0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = '0;
    logic [31:0] dat_o;
    logic ack_o;
    logic [BANK_W_DEF+F_W-1:0] mem_addr_o;
    logic mem_rd_o;
    logic mem_wr_o;
    logic [DATA_W-1:0] mem_wdata_o;
    logic [DATA_W-1:0] mem_rdata_i;
    logic busy_o;
    int n_errors = 0;
    int comparisons = 0;

    always #10 clk_i = ~clk_i;

    file_register_operand_decode file_register_operand_decode_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .mem_rdata_i(mem_rdata_i), .busy_o(busy_o)
    );

    data_memory_model data_memory_model_i (
        .clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i)
    );

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic w, input logic [WB_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask

    // start an instruction and measure how long busy stands
    task automatic run(input logic [INSTR_W-1:0] w, input int exp_busy);
        int n;
        logic [31:0] q;
        wb(1'b1, REG_INSTR, {18'h0, w}, q);
        n = 0;
        @(negedge clk_i);
        while (busy_o === 1'b1 && n < 20) begin
            n++;
            @(negedge clk_i);
        end
        check(32'(n), 32'(exp_busy));
    endtask

    initial begin
        logic [31:0] q;
        int r0;
        int w0;
        logic [15:0] p;
        logic [11:0] a;
        logic [1:0] mm;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, REG_ACC, 32'h0, q);
        check(q, {24'h0, ACC_RST});
        wb(1'b0, REG_PTR0, 32'h0, q);
        check(q, {16'h0, PTR_RST});
        wb(1'b0, 8'h3c, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, REG_BANK, 32'h3, q);
        data_memory_model_i.mem[12'h1a5] = 8'h41;
        r0 = data_memory_model_i.rd_cnt;
        w0 = data_memory_model_i.wr_cnt;
        run({2'h0, BOP_INC, 1'b1, 7'h25}, PHASES_PER_CYCLE);
        check({24'h0, data_memory_model_i.mem[12'h1a5]}, 32'h42);
        check(32'(data_memory_model_i.wr_cnt - w0), 32'h1);
        check({20'h0, data_memory_model_i.last_rd}, 32'h1a5);
        check({20'h0, data_memory_model_i.last_wr}, 32'h1a5);
        run({2'h0, BOP_INC, 1'b0, 7'h25}, PHASES_PER_CYCLE);
        wb(1'b0, REG_ACC, 32'h0, q);
        check(q, 32'h43);
        check({24'h0, data_memory_model_i.mem[12'h1a5]}, 32'h42);
        check(32'(data_memory_model_i.wr_cnt - w0), 32'h1);
        run({2'h0, BOP_STORE, 1'b1, 7'h7f}, PHASES_PER_CYCLE);
        check({24'h0, data_memory_model_i.mem[12'h1ff]}, 32'h43);
        check(32'(data_memory_model_i.rd_cnt - r0), 32'h3);
        for (int b = 0; b < 8; b++) begin
            run({2'h1, 2'h1, 3'(b), 7'h10}, PHASES_PER_CYCLE);
            check({24'h0, data_memory_model_i.mem[12'h190]}, 32'((2 << b) - 1));
        end
        run({2'h1, 2'h0, 3'h3, 7'h10}, PHASES_PER_CYCLE);
        check({24'h0, data_memory_model_i.mem[12'h190]}, 32'hf7);
        for (int m = 0; m < 4; m++) begin
            mm = 2'(m);
            p = mm[0] ? 16'h0240 : 16'h0120;
            for (int j = 0; j < 3; j++) begin
                a = 12'(p - 16'h1 + 16'(j));
                data_memory_model_i.mem[a] = a[7:0] ^ 8'h5a;
            end
            wb(1'b1, mm[0] ? REG_PTR1 : REG_PTR0, {16'h0, p}, q);
            run({2'h2, mm[0] ? 8'hff : 8'h00, 1'b0, mm[0], mm}, PHASES_PER_CYCLE);
            a = mm[1] ? p[11:0] : (mm[0] ? p[11:0] - 12'h1 : p[11:0] + 12'h1);
            wb(1'b0, REG_ACC, 32'h0, q);
            check(q, {24'h0, a[7:0] ^ 8'h5a});
            wb(1'b0, mm[0] ? REG_PTR1 : REG_PTR0, 32'h0, q);
            check(q, {16'h0, mm[0] ? p - 16'h1 : p + 16'h1});
        end
        wb(1'b1, REG_ACC, 32'hc3, q);
        wb(1'b1, REG_PTR0, 32'h0300, q);
        run({2'h2, 8'h00, 1'b1, 1'b0, MM_POST_INC}, PHASES_PER_CYCLE);
        check({24'h0, data_memory_model_i.mem[12'h300]}, 32'hc3);
        wb(1'b1, REG_PTR0, 32'h8010, q);
        data_memory_model_i.mem[12'h010] = 8'h11;
        r0 = data_memory_model_i.rd_cnt;
        run({2'h2, 8'hff, 1'b1, 1'b0, MM_POST_INC}, 2 * PHASES_PER_CYCLE);
        check({24'h0, data_memory_model_i.mem[12'h010]}, 32'h11);
        check(32'(data_memory_model_i.rd_cnt - r0), 32'h1);
        w0 = data_memory_model_i.wr_cnt;
        run(14'h3fff, PHASES_PER_CYCLE);
        wb(1'b0, REG_INSTR, 32'h0, q);
        check(q, 32'h3fff);
        wb(1'b0, REG_STATUS, 32'h0, q);
        check(q, {10'h0, 2'(CLS_NONE), 20'h0});
        check(32'(data_memory_model_i.wr_cnt - w0), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
